//--- inc/tgm_consts.svh
`ifndef TGM_CONSTS_SVH
`define TGM_CONSTS_SVH
`define TGM_WORD_W 64
`define TGM_SMALL_DEPTH 32
`define TGM_PROG_DEPTH 256
`define TGM_EXT_AW 18
`define TGM_OP_HI 63
`define TGM_OP_LO 61
`define TGM_OP_NOP 3'h0
`define TGM_OP_RUN 3'h1
`define TGM_OP_HALT 3'h3
`define TGM_OP_BMV 3'h5
`define TGM_EXT_HI 60
`define TGM_EXT_LO 43
`define TGM_CNT_HI 42
`define TGM_CNT_LO 35
`define TGM_SEL_HI 34
`define TGM_SEL_LO 30
`define TGM_DST_HI 29
`define TGM_DST_LO 22
`define TGM_SEL_ADDR 5'h10
`define TGM_SEL_STRM 5'h08
`define TGM_SEL_PROG 5'h04
`define TGM_SEL_PTR 5'h02
`define TGM_SEL_LOOP 5'h01
`define TGM_ADDR_W 56
`define TGM_STRM_W 37
`define TGM_PROG_W 54
`define TGM_PTR_W 8
`define TGM_LOOP_W 32
`define TGM_F_BIT 53
`define TGM_CTL_HI 52
`define TGM_CTL_LO 37
`define TGM_CNTG_HI 36
`define TGM_CNTG_LO 26
`define TGM_ADG_HI 25
`define TGM_ADG_LO 10
`define TGM_STG_HI 9
`define TGM_STG_LO 1
`define TGM_H_BIT 0
`define TGM_INC_HI 55
`define TGM_INC_LO 40
`define TGM_TAG_HI 39
`define TGM_TAG_LO 32
`define TGM_BASE_HI 31
`define TGM_SIZE_HI 34
`define TGM_SIZE_LO 32
`define TGM_DEPTH_HI 36
`define TGM_DEPTH_LO 32
`define TGM_STRIDE_HI 31
`define TGM_STRIDE_LO 16
`define TGM_LEN_HI 15
`define TGM_SIZE_32 3'h1
`define TGM_SIZE_64 3'h2
`define TGM_SIZE_128 3'h4
`endif

//--- inc/tgm_pkg.sv
package tgm_pkg;
  typedef enum logic [1:0] {TGM_SLOW_FETCH, TGM_SLOW_COPY, TGM_FAST, TGM_STOPPED} tgm_mode_e;
  typedef struct packed {
    logic freeze;
    logic [15:0] ctl;
    logic [10:0] cnt;
    logic [15:0] adr;
    logic [8:0] strm;
    logic halt;
  } tgm_fast_s;
endpackage : tgm_pkg

//--- inc/tgm_fast_if.sv
`timescale 1ns/10ps
interface tgm_fast_if;
  logic valid;
  logic [53:0] word;
  logic freeze;
  logic halt;
  modport src (output valid, output word, input freeze, input halt);
  modport dec (input valid, input word, output freeze, output halt);
endinterface : tgm_fast_if

//--- rtl/tgm_fast_decode.sv
`timescale 1ns/10ps
`include "tgm_consts.svh"
module tgm_fast_decode
  import tgm_pkg::*;
(
  tgm_fast_if.dec fif,
  output logic [15:0] o_ctl,
  output logic [10:0] o_cnt,
  output logic [15:0] o_adr,
  output logic [8:0] o_strm
);
  // One word drives all six groups in the same cycle
  always_comb
  begin
    fif.freeze = fif.valid & fif.word[`TGM_F_BIT];
    fif.halt = fif.valid & fif.word[`TGM_H_BIT];
    o_ctl = fif.word[`TGM_CTL_HI:`TGM_CTL_LO];
    o_cnt = fif.word[`TGM_CNTG_HI:`TGM_CNTG_LO];
    o_adr = fif.word[`TGM_ADG_HI:`TGM_ADG_LO];
    o_strm = fif.word[`TGM_STG_HI:`TGM_STG_LO];
  end
endmodule : tgm_fast_decode

//--- rtl/tgm_core.sv
`timescale 1ns/10ps
`include "tgm_consts.svh"
// Behaviour
// - Small memories 32 deep, program 256
// - Memories loaded only by slow copy
// - Seed: increment, tag, initial address
// - Seed gives start address and step
// - Tag carries access and miss attributes
// - Each stream needs two setup words
// - Base/size word sent before depth word
// - Base bits 31-0, size bits 34-32
// - Base is first item physical address
// - Length counts bytes of vector
// - Stride counts elements of item size
// - Program store holds 54-bit words
// - Pointer seed is 8-bit pointer
// - Loop count holds 32-bit start count
// - References only in fast mode
// - Fast word field layout decoded
// - All groups of a word act together
// - Freeze bit drives freeze line
// - Slow mode holds freeze line high
// - Halt bit returns to slow mode
// - Copy keeps only low bits
// - One-hot destination memory select
// - Copy moves count plus one words
module tgm_core
  import tgm_pkg::*;
#(
  parameter int EXT_AW = `TGM_EXT_AW
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [63:0] i_ext_data,
  output logic [EXT_AW-1:0] o_ext_addr,
  output logic o_freeze,
  output logic o_fast_mode,
  output logic o_stopped,
  output logic [15:0] o_ctl_grp,
  output logic [10:0] o_cnt_grp,
  output logic [15:0] o_adr_grp,
  output logic [8:0] o_strm_grp,
  input wire logic [4:0] i_seed_idx,
  output logic [15:0] o_seed_inc,
  output logic [7:0] o_seed_tag,
  output logic [31:0] o_seed_addr,
  input wire logic [4:0] i_strm_idx,
  output logic [36:0] o_strm_word,
  output logic o_strm_first,
  input wire logic [4:0] i_ptr_idx,
  output logic [7:0] o_ptr_val,
  input wire logic [4:0] i_loop_idx,
  output logic [31:0] o_loop_val
);
  tgm_mode_e mode_ff;
  logic [EXT_AW-1:0] pc_ff;
  logic [EXT_AW-1:0] src_ff;
  logic [7:0] left_ff;
  logic [4:0] sel_ff;
  logic [7:0] dst_ff;
  logic [7:0] ip_ff;
  logic data_ok_ff;
  logic [55:0] addr_mem [`TGM_SMALL_DEPTH];
  logic [36:0] strm_mem [`TGM_SMALL_DEPTH];
  logic [53:0] prog_mem [`TGM_PROG_DEPTH];
  logic [7:0] ptr_mem [`TGM_SMALL_DEPTH];
  logic [31:0] loop_mem [`TGM_SMALL_DEPTH];
  logic [53:0] prog_rd;
  logic [2:0] op;
  logic wr_en;
  tgm_fast_if fif ();
  logic [15:0] ctl_w;
  logic [10:0] cnt_w;
  logic [15:0] adr_w;
  logic [8:0] strm_w;

  assign op = i_ext_data[`TGM_OP_HI:`TGM_OP_LO];
  // First copy write waits one cycle after the copy address is set
  assign wr_en = (mode_ff == TGM_SLOW_COPY) && data_ok_ff;
  assign prog_rd = prog_mem[ip_ff];
  assign fif.valid = (mode_ff == TGM_FAST);
  assign fif.word = prog_rd;

  tgm_fast_decode u_dec (
    .fif(fif),
    .o_ctl(ctl_w),
    .o_cnt(cnt_w),
    .o_adr(adr_w),
    .o_strm(strm_w)
  );

  // Mode sequencing
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      mode_ff <= TGM_SLOW_FETCH;
      o_ext_addr <= '0;
      pc_ff <= '0;
      src_ff <= '0;
      left_ff <= 8'h00;
      sel_ff <= 5'h00;
      dst_ff <= 8'h00;
      ip_ff <= 8'h00;
      data_ok_ff <= 1'b0;
    end
    else
    begin
      case (mode_ff)
        TGM_SLOW_FETCH:
        begin
          data_ok_ff <= 1'b0;
          // Address out is the word wanted at the next edge
          if (op == `TGM_OP_BMV)
          begin
            mode_ff <= TGM_SLOW_COPY;
            src_ff <= EXT_AW'(i_ext_data[`TGM_EXT_HI:`TGM_EXT_LO]);
            o_ext_addr <= EXT_AW'(i_ext_data[`TGM_EXT_HI:`TGM_EXT_LO]);
            left_ff <= i_ext_data[`TGM_CNT_HI:`TGM_CNT_LO];
            sel_ff <= i_ext_data[`TGM_SEL_HI:`TGM_SEL_LO];
            dst_ff <= i_ext_data[`TGM_DST_HI:`TGM_DST_LO];
            pc_ff <= pc_ff + 1'b1;
          end
          else if (op == `TGM_OP_RUN)
          begin
            mode_ff <= TGM_FAST;
            ip_ff <= ptr_mem[0];
            pc_ff <= pc_ff + 1'b1;
            o_ext_addr <= pc_ff + 1'b1;
          end
          else if (op == `TGM_OP_HALT)
            mode_ff <= TGM_STOPPED;
          else
          begin
            pc_ff <= pc_ff + 1'b1;
            o_ext_addr <= pc_ff + 1'b1;
          end
        end
        TGM_SLOW_COPY:
        begin
          data_ok_ff <= 1'b1;
          if (data_ok_ff)
          begin
            dst_ff <= dst_ff + 1'b1;
            src_ff <= src_ff + 1'b1;
            // Count of zero still moves one word
            if (left_ff == 8'h00)
            begin
              mode_ff <= TGM_SLOW_FETCH;
              data_ok_ff <= 1'b0;
              o_ext_addr <= pc_ff;
            end
            else
            begin
              left_ff <= left_ff - 1'b1;
              o_ext_addr <= src_ff + 1'b1;
            end
          end
        end
        TGM_FAST:
        begin
          if (fif.halt)
            mode_ff <= TGM_SLOW_FETCH;
          else
            ip_ff <= ip_ff + 1'b1;
        end
        TGM_STOPPED:
          mode_ff <= TGM_STOPPED;
        default:
          mode_ff <= TGM_SLOW_FETCH;
      endcase
    end
  end

  // Low bits only reach each memory
  always_ff @(posedge i_clk)
  begin
    if (wr_en)
    begin
      case (sel_ff)
        `TGM_SEL_ADDR: addr_mem[dst_ff[4:0]] <= i_ext_data[`TGM_ADDR_W-1:0];
        `TGM_SEL_STRM: strm_mem[dst_ff[4:0]] <= i_ext_data[`TGM_STRM_W-1:0];
        `TGM_SEL_PROG: prog_mem[dst_ff] <= i_ext_data[`TGM_PROG_W-1:0];
        `TGM_SEL_PTR: ptr_mem[dst_ff[4:0]] <= i_ext_data[`TGM_PTR_W-1:0];
        `TGM_SEL_LOOP: loop_mem[dst_ff[4:0]] <= i_ext_data[`TGM_LOOP_W-1:0];
        default: ;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_freeze <= 1'b1;
      o_fast_mode <= 1'b0;
      o_stopped <= 1'b0;
      o_ctl_grp <= 16'h0000;
      o_cnt_grp <= 11'h000;
      o_adr_grp <= 16'h0000;
      o_strm_grp <= 9'h000;
    end
    else
    begin
      o_freeze <= (mode_ff != TGM_FAST) || fif.freeze;
      o_fast_mode <= (mode_ff == TGM_FAST);
      o_stopped <= (mode_ff == TGM_STOPPED);
      // Groups idle outside fast mode
      o_ctl_grp <= fif.valid ? ctl_w : 16'h0000;
      o_cnt_grp <= fif.valid ? cnt_w : 11'h000;
      o_adr_grp <= fif.valid ? adr_w : 16'h0000;
      o_strm_grp <= fif.valid ? strm_w : 9'h000;
    end
  end

  // Seed and setup read ports, registered
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_seed_inc <= 16'h0000;
      o_seed_tag <= 8'h00;
      o_seed_addr <= 32'h0000_0000;
      o_strm_word <= 37'h0;
      o_strm_first <= 1'b0;
      o_ptr_val <= 8'h00;
      o_loop_val <= 32'h0000_0000;
    end
    else
    begin
      o_seed_inc <= addr_mem[i_seed_idx][`TGM_INC_HI:`TGM_INC_LO];
      o_seed_tag <= addr_mem[i_seed_idx][`TGM_TAG_HI:`TGM_TAG_LO];
      o_seed_addr <= addr_mem[i_seed_idx][`TGM_BASE_HI:0];
      // Even entry holds base/size, odd holds depth/stride/length
      o_strm_word <= strm_mem[i_strm_idx];
      o_strm_first <= ~i_strm_idx[0];
      o_ptr_val <= ptr_mem[i_ptr_idx];
      o_loop_val <= loop_mem[i_loop_idx];
    end
  end

  a_freeze_slow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_ff != TGM_FAST) |=> o_freeze)
    else $error("freeze low in slow mode");
  a_freeze_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_ff == TGM_FAST && prog_rd[`TGM_F_BIT]) |=> o_freeze)
    else $error("freeze bit not driven");
  a_halt_exit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_ff == TGM_FAST && prog_rd[`TGM_H_BIT]) |=> mode_ff == TGM_SLOW_FETCH)
    else $error("halt did not leave fast mode");
  a_write_slow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_en |-> mode_ff != TGM_FAST)
    else $error("memory written in fast mode");
  a_groups_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_ff != TGM_FAST) |=> o_adr_grp == 16'h0000 && o_strm_grp == 9'h000)
    else $error("group active outside fast mode");
  a_copy_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_ff == TGM_SLOW_COPY && data_ok_ff && left_ff == 8'h00) |=> mode_ff == TGM_SLOW_FETCH)
    else $error("copy overran count");
  a_copy_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_ff == TGM_SLOW_FETCH && op == `TGM_OP_BMV) |=> !wr_en ##1 wr_en)
    else $error("copy missed first word");
  a_fast_ip: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_ff == TGM_FAST && !prog_rd[`TGM_H_BIT]) |=> ip_ff == $past(ip_ff) + 8'h01)
    else $error("pointer did not advance");
endmodule : tgm_core

//--- dv/tgm_store_model.sv
`timescale 1ns/10ps
module tgm_store_model #(
  parameter int AW = 18
)
(
  input wire logic i_clk,
  input wire logic [AW-1:0] i_addr,
  output logic [63:0] o_data
);
  logic [63:0] mem [0:63];
  // Beyond the image reads all ones, so a stray fetch is never a clean NOP
  // Answers within the cycle the address stands
  assign o_data = (i_addr < AW'(64)) ? mem[i_addr[5:0]] : '1;
endmodule : tgm_store_model

//--- dv/trace_gen_memory_and_word_formats_bench.sv
`timescale 1ns/10ps
`include "tgm_consts.svh"
module trace_gen_memory_and_word_formats_bench;
  logic i_clk;
  logic i_rst_n;
  logic [4:0] idx;
  logic [17:0] ext_addr;
  logic [63:0] ext_data;
  logic freeze, fast, stopped, sfirst, prev_slow;
  logic [15:0] ctl, adr, s_inc;
  logic [10:0] cnt;
  logic [8:0] strm;
  logic [7:0] s_tag, pv;
  logic [31:0] s_addr, lv;
  logic [36:0] sw;
  logic [63:0] rng, p0, p1;
  int fails, tests_run, cyc, hit0, hit1, lo_seen, hi_after, slow_bad;

  tgm_core #(.EXT_AW(18)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ext_data(ext_data), .o_ext_addr(ext_addr),
    .o_freeze(freeze), .o_fast_mode(fast), .o_stopped(stopped), .o_ctl_grp(ctl), .o_cnt_grp(cnt),
    .o_adr_grp(adr), .o_strm_grp(strm), .i_seed_idx(idx), .o_seed_inc(s_inc), .o_seed_tag(s_tag),
    .o_seed_addr(s_addr), .i_strm_idx(idx), .o_strm_word(sw), .o_strm_first(sfirst), .i_ptr_idx(idx),
    .o_ptr_val(pv), .i_loop_idx(idx), .o_loop_val(lv));
  tgm_store_model #(.AW(18)) st (.i_clk(i_clk), .i_addr(ext_addr), .o_data(ext_data));

  always #2.5 i_clk = ~i_clk;

  function automatic logic [63:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 7;
    rng ^= rng << 17;
    return rng;
  endfunction : xs

  function automatic logic [63:0] block_copy_op(input int ext, input int n, input logic [4:0] sel, input int dst);
    return {`TGM_OP_BMV, 18'(ext), 8'(n), sel, 8'(dst), 22'h0};
  endfunction : block_copy_op

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [4:0] i);
    @(posedge i_clk);
    idx <= i;
    @(posedge i_clk);
    @(posedge i_clk);
    @(negedge i_clk);
  endtask : rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Freeze lags mode by a cycle, so slow mode is judged only once settled
  always @(negedge i_clk)
  begin
    if (i_rst_n === 1'b1 && fast === 1'b1)
    begin
      hit0 += ({ctl, cnt, adr, strm} === p0[52:1]);
      hit1 += ({ctl, cnt, adr, strm} === p1[52:1]);
      lo_seen += (freeze === 1'b0);
      hi_after += (freeze === 1'b1 && lo_seen > 0);
    end
    slow_bad += (prev_slow && fast === 1'b0 && freeze !== 1'b1);
    prev_slow = (i_rst_n === 1'b1 && fast === 1'b0);
  end

  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fails++;
      end_sim();
    end
  end

  initial
  begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    idx = '0;
    rng = 64'd44061;
    prev_slow = 1'b0;
    for (int i = 0; i < 64; i++)
      st.mem[i] = xs();
    for (int i = 0; i < 16; i++)
      st.mem[i] = 64'h0;
    p0 = xs();
    p0[53] = 1'b0;
    p0[0] = 1'b0;
    p1 = xs();
    p1[53] = 1'b1;
    p1[0] = 1'b0;
    st.mem[16] = p0;
    st.mem[17] = p1;
    for (int i = 18; i < 22; i++)
      st.mem[i] = {10'(xs()), 54'h1};
    st.mem[24] = xs() & ~64'hff;
    st.mem[28][34:32] = 3'(1 << (xs() % 3));
    st.mem[29][36:32] = 5'(1 << (xs() % 5));
    st.mem[31][7:0] = 8'h5a;
    st.mem[0] = block_copy_op(16, 5, `TGM_SEL_PROG, 0);
    st.mem[1] = block_copy_op(24, 1, `TGM_SEL_PTR, 0);
    st.mem[2] = block_copy_op(26, 1, `TGM_SEL_ADDR, 5);
    st.mem[3] = block_copy_op(28, 1, `TGM_SEL_STRM, 0);
    st.mem[4] = block_copy_op(30, 0, `TGM_SEL_LOOP, 31);
    st.mem[5] = block_copy_op(31, 0, 5'h03, 0);
    st.mem[6] = {`TGM_OP_RUN, 61'h0};
    st.mem[8] = {`TGM_OP_HALT, 61'h0};
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 1000 && stopped !== 1'b1; k++)
      @(posedge i_clk);
    chk(stopped, 1);
    chk(hit0 > 0, 1);
    chk(hit1 > 0, 1);
    chk(hi_after > 0, 1);
    chk(slow_bad, 0);
    $display("fast run test done");
    rd(5);
    chk({s_inc, s_tag, s_addr}, st.mem[26][55:0]);
    rd(6);
    chk({s_inc, s_tag, s_addr}, st.mem[27][55:0]);
    rd(0);
    chk({sfirst, sw}, {1'b1, st.mem[28][36:0]});
    chk(pv, 8'h00);
    rd(1);
    chk({sfirst, sw}, {1'b0, st.mem[29][36:0]});
    chk(pv, st.mem[25][7:0]);
    rd(31);
    chk(lv, st.mem[30][31:0]);
    $display("memory test done");
    end_sim();
  end
endmodule : trace_gen_memory_and_word_formats_bench
